// ===== design/vtdvs_pkg.sv
// Package for the output-voltage target and scaling control block
// Assumes a single 125 MHz clock domain, synchronous active-high reset
package vtdvs_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CODE_W  = 12;
  // Target code limits per divider ratio (code = volts / step)
  localparam logic [11:0] CODE_MIN_DIV10 = 12'h064; // 1.0V / 10mV
  localparam logic [11:0] CODE_MAX_DIV10 = 12'h960; // 24V / 10mV
  localparam logic [11:0] CODE_MIN_DIV20 = 12'h0a5; // 3.3V / 20mV
  localparam logic [11:0] CODE_MAX_DIV20 = 12'h960; // 48V / 20mV
  localparam logic [11:0] RST_TARGET     = 12'h064;
  // Default scaling step interval, in ns, and its cycle count
  localparam int STEP_TIME_NS   = 1000;
  localparam int STEP_CYCLES    = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES    = 3;
  typedef enum {ST_SHUTDOWN, ST_STANDBY, ST_PREBIAS, ST_RUN} vtdvs_state_t;
endpackage : vtdvs_pkg

// ===== design/vtdvs_sync.sv
// Three-stage synchroniser with agreement filter for one pin level
// Assumes pin is asynchronous to sys_clk
`timescale 1ns/1ps
module vtdvs_sync (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level_out
);
  typedef struct packed {
    logic [2:0] stg;
    logic       lvl;
  } vtdvs_sync_t;
  vtdvs_sync_t s_r;
  vtdvs_sync_t s_nxt;
  always_comb begin
    s_nxt     = s_r;
    s_nxt.stg = {s_r.stg[1:0], pin_in};
    // Accept only when the second and third stages agree
    if (s_r.stg[1] == s_r.stg[2]) begin
      s_nxt.lvl = s_r.stg[2];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign level_out = s_r.lvl;
endmodule : vtdvs_sync

// ===== design/vtdvs_core.sv
// Output-voltage target, feedback latch, regulator sequencing and scaling
// Assumes comparator outputs as async pins; config bits from same clock
`timescale 1ns/1ps
// Contract
// RULE1: Aux regulator waits strap readout, then enables
// RULE2: Aux regulator starts on entering standby
// RULE3: Gate regulator prebias on release, full on enable
// RULE4: Feedback choice latched before soft-start
// RULE5: Ratio clear: 1.0V to 24V, 10mV
// RULE6: Ratio set: 3.3V to 48V, 20mV
// RULE7: Code is upper nibble above lower byte
// RULE8: Readback below minimum returns minimum code
// RULE9: Readback above maximum returns maximum code
// RULE10: Host rewrites target after ratio change
// RULE11: Internal feedback senses output pin
// RULE12: Reference slews toward target, limited slope
// RULE13: Target written while off: start ramps there
// RULE14: Power save blocks negative inductor current
// RULE15: Active scaling discharges on falling ramps
// RULE16: Active scaling discharge uses maximum strength
// RULE17: Clamped target is the regulation endpoint
module vtdvs_core #(
  parameter int STEP_CYCLES = vtdvs_pkg::STEP_CYCLES,
  parameter int STEP_LSB    = 1
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        shutdown_release_pin,
  input  wire logic        enable_undervoltage_pin,
  input  wire logic        feedback_pin,
  input  wire logic        strap_readout_done,
  input  wire logic        strap_aux_enable,
  input  wire logic        reg_aux_enable,
  input  wire logic        reg_aux_override,
  input  wire logic        soft_start_begin,
  input  wire logic        converter_running,
  input  wire logic        power_save_operation,
  input  wire logic        active_scaling_select,
  input  wire logic        divider_ratio_select,
  input  wire logic        target_write,
  input  wire logic [7:0]  target_code_upper_byte,
  input  wire logic [7:0]  target_code_lower_byte,
  input  wire logic [2:0]  discharge_strength_reg,
  input  wire logic        discharge_request,
  output logic             auxiliary_regulator_en,
  output logic             gate_drive_prebias,
  output logic             gate_drive_full,
  output logic             internal_feedback_sel,
  output logic             sense_from_output_pin,
  output logic [11:0]      output_voltage_target,
  output logic [11:0]      reference_code,
  output logic             discharge_en,
  output logic [2:0]       discharge_strength,
  output logic             negative_current_block
);
  typedef struct packed {
    vtdvs_pkg::vtdvs_state_t st;
    logic        aux;
    logic        pre;
    logic        full;
    logic        fb_latched;
    logic        fb_int;
    logic [11:0] tgt;
    logic [11:0] ref_c;
    logic [15:0] cnt;
    logic        dis;
    logic [2:0]  str;
    logic        negblk;
  } vtdvs_core_t;

  vtdvs_core_t s_r;
  vtdvs_core_t s_nxt;
  logic        rel_lvl;
  logic        en_lvl;
  logic        fb_lvl;
  logic [11:0] raw_code;
  logic [11:0] cmin;
  logic [11:0] cmax;
  logic [11:0] clamped;
  logic        falling;

  vtdvs_sync u_sync_rel (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_in    (shutdown_release_pin),
    .level_out (rel_lvl)
  );
  vtdvs_sync u_sync_en (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_in    (enable_undervoltage_pin),
    .level_out (en_lvl)
  );
  vtdvs_sync u_sync_fb (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_in    (feedback_pin),
    .level_out (fb_lvl)
  );

  // Code assembly and range limits
  assign raw_code = {target_code_upper_byte[3:0],
                     target_code_lower_byte}; // RULE7
  assign cmin = divider_ratio_select ? vtdvs_pkg::CODE_MIN_DIV20
                                     : vtdvs_pkg::CODE_MIN_DIV10; // RULE5
  assign cmax = divider_ratio_select ? vtdvs_pkg::CODE_MAX_DIV20
                                     : vtdvs_pkg::CODE_MAX_DIV10; // RULE6
  always_comb begin
    if (raw_code < cmin) begin
      clamped = cmin; // RULE8
    end else if (raw_code > cmax) begin
      clamped = cmax; // RULE9
    end else begin
      clamped = raw_code;
    end
  end
  assign falling = (s_r.ref_c > s_r.tgt);

  always_comb begin
    s_nxt = s_r;
    // Sequencing
    case (s_r.st)
      vtdvs_pkg::ST_SHUTDOWN: begin
        if (rel_lvl) begin
          s_nxt.st = vtdvs_pkg::ST_STANDBY;
        end
      end
      vtdvs_pkg::ST_STANDBY, vtdvs_pkg::ST_PREBIAS: begin
        s_nxt.st = en_lvl ? vtdvs_pkg::ST_RUN : vtdvs_pkg::ST_PREBIAS;
        if (!rel_lvl) begin
          s_nxt.st = vtdvs_pkg::ST_SHUTDOWN;
        end
      end
      vtdvs_pkg::ST_RUN: begin
        if (!rel_lvl) begin
          s_nxt.st = vtdvs_pkg::ST_SHUTDOWN;
        end else if (!en_lvl) begin
          s_nxt.st = vtdvs_pkg::ST_PREBIAS;
        end
      end
      default: s_nxt.st = vtdvs_pkg::ST_SHUTDOWN;
    endcase
    // Aux regulator from standby on, gated by strap readout
    s_nxt.aux = (s_r.st != vtdvs_pkg::ST_SHUTDOWN) && rel_lvl
                && strap_readout_done
                && (reg_aux_override ? reg_aux_enable
                                     : strap_aux_enable); // RULE1 RULE2
    s_nxt.pre  = rel_lvl && !en_lvl; // RULE3
    s_nxt.full = rel_lvl && en_lvl; // RULE3
    // Feedback choice latched once per enable cycle
    if (!en_lvl || !rel_lvl) begin
      s_nxt.fb_latched = 1'b0;
    end else if (soft_start_begin && !s_r.fb_latched) begin
      s_nxt.fb_latched = 1'b1; // RULE4
      s_nxt.fb_int     = fb_lvl; // RULE4
    end
    // Target storage, always the clamped value
    if (target_write) begin
      s_nxt.tgt = clamped; // RULE17
    end
    if (!converter_running) begin
      s_nxt.ref_c = s_nxt.tgt; // RULE13
      s_nxt.cnt   = '0;
    end else if (s_r.ref_c != s_r.tgt) begin
      if (s_r.cnt >= 16'(STEP_CYCLES - 1)) begin
        s_nxt.cnt = '0;
        if (falling) begin
          s_nxt.ref_c = (s_r.ref_c - s_r.tgt > 12'(STEP_LSB))
                      ? s_r.ref_c - 12'(STEP_LSB) : s_r.tgt; // RULE12
        end else begin
          s_nxt.ref_c = (s_r.tgt - s_r.ref_c > 12'(STEP_LSB))
                      ? s_r.ref_c + 12'(STEP_LSB) : s_r.tgt; // RULE12
        end
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end else begin
      s_nxt.cnt = '0;
    end
    // Discharge control
    if (converter_running && active_scaling_select && falling) begin
      s_nxt.dis = 1'b1; // RULE15
      s_nxt.str = 3'h7; // RULE16
    end else begin
      s_nxt.dis = discharge_request;
      s_nxt.str = discharge_strength_reg;
    end
    s_nxt.negblk = converter_running && power_save_operation; // RULE14
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r       <= '0;
      s_r.st    <= vtdvs_pkg::ST_SHUTDOWN;
      s_r.tgt   <= vtdvs_pkg::RST_TARGET;
      s_r.ref_c <= vtdvs_pkg::RST_TARGET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign auxiliary_regulator_en = s_r.aux;
  assign gate_drive_prebias     = s_r.pre;
  assign gate_drive_full        = s_r.full;
  assign internal_feedback_sel  = s_r.fb_int;
  assign sense_from_output_pin  = s_r.fb_int; // RULE11
  assign output_voltage_target  = s_r.tgt;
  assign reference_code         = s_r.ref_c;
  assign discharge_en           = s_r.dis;
  assign discharge_strength     = s_r.str;
  assign negative_current_block = s_r.negblk;

  a_aux_gated: assert property (@(posedge sys_clk) disable iff (reset)
    auxiliary_regulator_en |-> $past(strap_readout_done))
    else $error("aux enabled before strap readout"); // RULE1
  a_aux_shutdown: assert property (@(posedge sys_clk) disable iff (reset)
    $past(s_r.st == vtdvs_pkg::ST_SHUTDOWN) |-> !auxiliary_regulator_en)
    else $error("aux on in shutdown"); // RULE2
  a_gate_excl: assert property (@(posedge sys_clk) disable iff (reset)
    !(gate_drive_prebias && gate_drive_full))
    else $error("gate prebias and full together"); // RULE3
  a_fb_hold: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.fb_latched && $past(s_r.fb_latched) |-> $stable(s_r.fb_int))
    else $error("feedback choice changed"); // RULE4
  a_tgt_range: assert property (@(posedge sys_clk) disable iff (reset)
    $past(target_write) |-> output_voltage_target >= $past(cmin)
      && output_voltage_target <= $past(cmax))
    else $error("target outside clamp"); // RULE8
  a_tgt_code: assert property (@(posedge sys_clk) disable iff (reset)
    target_write && raw_code >= cmin && raw_code <= cmax
      |=> output_voltage_target == $past(raw_code))
    else $error("target code mismatch"); // RULE7
  a_ref_step: assert property (@(posedge sys_clk) disable iff (reset)
    $past(converter_running) && converter_running
      |-> (reference_code - $past(reference_code) <= 12'(STEP_LSB))
       || ($past(reference_code) - reference_code <= 12'(STEP_LSB)))
    else $error("reference slew too fast"); // RULE12
  a_off_track: assert property (@(posedge sys_clk) disable iff (reset)
    !converter_running |=> reference_code == output_voltage_target)
    else $error("reference not at target while off"); // RULE13
  a_dis_max: assert property (@(posedge sys_clk) disable iff (reset)
    converter_running && active_scaling_select && falling
      |=> discharge_en && discharge_strength == 3'h7)
    else $error("active scaling discharge wrong"); // RULE16
  a_negblk: assert property (@(posedge sys_clk) disable iff (reset)
    converter_running && power_save_operation |=> negative_current_block)
    else $error("negative current not blocked"); // RULE14
endmodule : vtdvs_core

// ===== testbench/vtdvs_host_model.sv
// Host model issuing one-cycle target writes with both bytes
// Assumes the bench raises go for one cycle per write
`timescale 1ns/1ps
module vtdvs_host_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [11:0] code,
  input  wire logic [3:0]  pad,
  output logic             target_write,
  output logic [7:0]       target_code_upper_byte,
  output logic [7:0]       target_code_lower_byte
);
  initial begin
    target_write = 1'b0;
    target_code_upper_byte = 8'h00;
    target_code_lower_byte = 8'h00;
  end
  always @(posedge sys_clk) begin
    target_write <= go;
    if (go) begin
      target_code_upper_byte <= {pad, code[11:8]};
      target_code_lower_byte <= code[7:0];
    end else begin
      // Released bytes toggle so stale data never looks valid
      target_code_upper_byte <= ~target_code_upper_byte;
      target_code_lower_byte <= ~target_code_lower_byte;
    end
  end
endmodule : vtdvs_host_model

// ===== testbench/vtdvs_tb.sv
// Self-checking bench for the target and scaling control block
// Assumes the host model supplies writes; bench drives pins and config
`timescale 1ns/1ps
module vtdvs_tb;
  localparam int STEP = 2;
  logic sys_clk = 1'b0, reset = 1'b1, go = 1'b0, target_write;
  logic shutdown_release_pin = 1'b0, enable_undervoltage_pin = 1'b0;
  logic feedback_pin = 1'b0, strap_readout_done = 1'b0;
  logic strap_aux_enable = 1'b1, reg_aux_enable = 1'b0;
  logic reg_aux_override = 1'b0, soft_start_begin = 1'b0;
  logic converter_running = 1'b0, power_save_operation = 1'b0;
  logic active_scaling_select = 1'b0, divider_ratio_select = 1'b0;
  logic discharge_request = 1'b0, auxiliary_regulator_en, discharge_en;
  logic gate_drive_prebias, gate_drive_full, internal_feedback_sel;
  logic sense_from_output_pin, negative_current_block;
  logic [2:0] discharge_strength_reg = 3'h2, discharge_strength;
  logic [3:0] pad = 4'h0;
  logic [7:0] target_code_upper_byte, target_code_lower_byte;
  logic [11:0] code = 12'h000, output_voltage_target, reference_code;
  logic [11:0] corner [8] = '{12'h000, 12'h063, 12'h064, 12'h0a4,
                             12'h0a5, 12'h960, 12'h961, 12'hfff};
  logic [31:0] rnd = 32'he1f57968;
  int checks = 0, miscompares = 0, n = 0;

  vtdvs_host_model host (.sys_clk, .go, .code, .pad, .target_write,
    .target_code_upper_byte, .target_code_lower_byte);
  vtdvs_core #(.STEP_CYCLES(STEP)) DUT (.sys_clk, .reset,
    .shutdown_release_pin, .enable_undervoltage_pin, .feedback_pin,
    .strap_readout_done, .strap_aux_enable, .reg_aux_enable,
    .reg_aux_override, .soft_start_begin, .converter_running,
    .power_save_operation, .active_scaling_select, .divider_ratio_select,
    .target_write, .target_code_upper_byte, .target_code_lower_byte,
    .discharge_strength_reg, .discharge_request, .auxiliary_regulator_en,
    .gate_drive_prebias, .gate_drive_full, .internal_feedback_sel,
    .sense_from_output_pin, .output_voltage_target, .reference_code,
    .discharge_en, .discharge_strength, .negative_current_block);

  initial forever #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [11:0] clamp(input logic [11:0] c, input logic r);
    logic [11:0] lo, hi;
    lo = r ? vtdvs_pkg::CODE_MIN_DIV20 : vtdvs_pkg::CODE_MIN_DIV10;
    hi = r ? vtdvs_pkg::CODE_MAX_DIV20 : vtdvs_pkg::CODE_MAX_DIV10;
    return (c < lo) ? lo : ((c > hi) ? hi : c);
  endfunction : clamp
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Settle at the falling edge after k rising edges
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc
  task automatic write_code(input logic [11:0] c);
    @(posedge sys_clk);
    rnd = lfsr(rnd);
    go <= 1'b1;
    code <= c;
    pad <= rnd[3:0];
    @(posedge sys_clk);
    go <= 1'b0;
    cyc(3);
  endtask : write_code
  task automatic wait_ref(input logic [11:0] exp);
    for (n = 0; n < 1000 && reference_code !== exp; n++) @(negedge sys_clk);
    if (n == 1000) begin
      miscompares++;
      results();
    end
  endtask : wait_ref

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(1);
    check(output_voltage_target, vtdvs_pkg::RST_TARGET);
    check({11'h000, gate_drive_prebias}, 12'h000);
    @(posedge sys_clk);
    shutdown_release_pin <= 1'b1;
    cyc(8);
    check({11'h000, gate_drive_prebias}, 12'h001);
    check({11'h000, auxiliary_regulator_en}, 12'h000);
    @(posedge sys_clk);
    strap_readout_done <= 1'b1;
    cyc(8);
    check({11'h000, auxiliary_regulator_en}, 12'h001);
    @(posedge sys_clk);
    reg_aux_override <= 1'b1;
    cyc(3);
    check({11'h000, auxiliary_regulator_en}, 12'h000);
    @(posedge sys_clk);
    enable_undervoltage_pin <= 1'b1;
    feedback_pin <= 1'b1;
    cyc(8);
    check({10'h000, gate_drive_full, gate_drive_prebias}, 12'h002);
    // Latch, hold across enable low, relatch on the next enable cycle
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      soft_start_begin <= 1'b1;
      @(posedge sys_clk);
      soft_start_begin <= 1'b0;
      feedback_pin <= 1'b0;
      cyc(8);
      check({11'h000, internal_feedback_sel}, {11'h000, k == 0});
      check({11'h000, sense_from_output_pin}, {11'h000, k == 0});
      @(posedge sys_clk);
      enable_undervoltage_pin <= 1'b0;
      cyc(8);
      check({11'h000, internal_feedback_sel}, {11'h000, k == 0});
      @(posedge sys_clk);
      enable_undervoltage_pin <= 1'b1;
      cyc(8);
    end
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      divider_ratio_select <= (i < 16) ? i[0] : rnd[12];
      write_code((i < 16) ? corner[i[3:1]] : rnd[11:0]);
      check(output_voltage_target, clamp(code, divider_ratio_select));
      check(reference_code, clamp(code, divider_ratio_select));
    end
    @(posedge sys_clk);
    divider_ratio_select <= 1'b0;
    write_code(12'h070);
    @(posedge sys_clk);
    divider_ratio_select <= 1'b1;
    cyc(3);
    check(output_voltage_target, 12'h070);
    write_code(12'h070);
    check(output_voltage_target, vtdvs_pkg::CODE_MIN_DIV20);
    @(posedge sys_clk);
    divider_ratio_select <= 1'b0;
    write_code(12'h064);
    @(posedge sys_clk);
    converter_running <= 1'b1;
    power_save_operation <= 1'b1;
    cyc(3);
    check({11'h000, negative_current_block}, 12'h001);
    for (int a = 1; a >= 0; a--) begin
      @(posedge sys_clk);
      active_scaling_select <= a[0];
      write_code(12'h0c8);
      check({11'h000, reference_code < 12'h06a}, 12'h001);
      wait_ref(12'h0c8);
      check({11'h000, n >= 180}, 12'h001);
      write_code(12'h064);
      check({8'h00, discharge_en, discharge_strength},
            a[0] ? 12'h00f : {9'h000, discharge_strength_reg});
      wait_ref(12'h064);
      check({11'h000, n >= 180}, 12'h001);
      write_code(12'h000);
      wait_ref(12'h064);
      check(reference_code, vtdvs_pkg::CODE_MIN_DIV10);
    end
    results();
  end
endmodule : vtdvs_tb
